//--- hsp_dev.sv
// Purpose: two-wire slave giving a bus master access to a register space
// Assumes: link_clk runs free and far faster than the bus clock
// Notes:   register space lives outside, reached by strobes on sys_clk
`timescale 1ns/100ps
// Function
// - slave only, never starts, stops or arbitrates
// - latch select pin when reset releases
// - answer B8h or BAh per latched select
// - read phase uses same select-based address
// - works up to 400 kbit/s
// - data changes only while clock low
// - detect start and stop while clock high
// - eight bits then one acknowledge per byte
// - master clocks the acknowledge pulse
// - write: start, address MSB first, bit zero
// - sub-address loads the register pointer
// - acknowledge and store every written byte
// - master stops after last write acknowledge
// - read address phase then immediate stop
// - read: address bit one, bytes out MSB first
// - master acknowledges all but last read byte
// - drive lines only low, pull-ups give high
module hsp_dev (
	// user side, system clock
	input  wire logic       sys_clk,
	input  wire logic       rst,
	output logic            reg_wr,
	output logic [7:0]      reg_waddr,
	output logic [7:0]      reg_wdata,
	output logic            reg_rd,
	output logic [7:0]      reg_raddr,
	input  wire logic [7:0] reg_rdata,
	// link side
	input  wire logic       link_clk,
	input  wire logic       slave_address_select,
	hsp_if.dev              bus
);

	// ------------------------------------------------------------
	// link domain reset and pin synchronisers
	// ------------------------------------------------------------
	logic lrst_m;
	logic lrst;
	logic scl_m;
	logic scl_s;
	logic scl_p;
	logic sda_m;
	logic sda_s;
	logic sda_p;
	logic sel_m;
	logic sel_s;
	logic sel_q;

	always_ff @(posedge link_clk) begin
		lrst_m <= rst;
		lrst   <= lrst_m;
	end

	always_ff @(posedge link_clk) begin
		scl_m <= bus.scl;
		scl_s <= scl_m;
		scl_p <= scl_s;
		sda_m <= bus.sda;
		sda_s <= sda_m;
		sda_p <= sda_s;
		sel_m <= slave_address_select;
		sel_s <= sel_m;
	end

	// follows the pin throughout reset, frozen from the release on
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			sel_q <= sel_s;
		end
	end

	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic [7:0] my_addr;

	assign rise    = scl_s & ~scl_p;
	assign fall    = ~scl_s & scl_p;
	assign start   = scl_s & scl_p & sda_p & ~sda_s;
	assign stop    = scl_s & scl_p & ~sda_p & sda_s;
	assign my_addr = sel_q ? hsp_pkg::ADDR_SEL1 : hsp_pkg::ADDR_SEL0;

	// ------------------------------------------------------------
	// byte engine on the link clock
	// ------------------------------------------------------------
	hsp_pkg::hsp_dev_st_e st_q;
	hsp_pkg::hsp_phase_e  ph_q;
	logic [3:0]           cnt_q;
	logic [7:0]           sh_q;
	logic [7:0]           tx_q;
	logic [7:0]           ptr_q;
	logic [7:0]           wa_q;
	logic [7:0]           wd_q;
	logic [7:0]           rdat_q;
	logic                 rw_q;
	logic                 mack_q;
	logic                 sda_oe_q;
	logic                 lo_q;
	logic                 wr_ev_q;
	logic                 rd_ev_q;

	always_ff @(posedge link_clk) begin
		wr_ev_q <= 1'b0;
		rd_ev_q <= 1'b0;
		if (lrst) begin
			st_q     <= hsp_pkg::ST_IDLE;
			ph_q     <= hsp_pkg::PH_ADDR;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			tx_q     <= 8'h00;
			ptr_q    <= hsp_pkg::PTR_RST;
			wa_q     <= 8'h00;
			wd_q     <= 8'h00;
			rw_q     <= 1'b0;
			mack_q   <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start) begin
			// repeated start is legal anywhere, even mid-byte
			st_q     <= hsp_pkg::ST_RX;
			ph_q     <= hsp_pkg::PH_ADDR;
			cnt_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop) begin
			st_q     <= hsp_pkg::ST_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (st_q)
			hsp_pkg::ST_RX: begin
				if (rise) begin
					sh_q  <= {sh_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end else if (fall && cnt_q == hsp_pkg::BYTE_BITS) begin
					cnt_q    <= 4'h0;
					st_q     <= hsp_pkg::ST_RACK;
					sda_oe_q <= 1'b1;
					case (ph_q)
					hsp_pkg::PH_ADDR: begin
						if (sh_q[7:1] != my_addr[7:1]) begin
							st_q     <= hsp_pkg::ST_WAIT;
							sda_oe_q <= 1'b0;
						end else begin
							rw_q    <= sh_q[hsp_pkg::RW_BIT];
							rd_ev_q <= sh_q[hsp_pkg::RW_BIT];
						end
					end
					hsp_pkg::PH_SUB: begin
						ptr_q <= sh_q;
					end
					default: begin
						wa_q    <= ptr_q;
						wd_q    <= sh_q;
						wr_ev_q <= 1'b1;
						ptr_q   <= ptr_q + 8'h01;
					end
					endcase
				end
			end
			hsp_pkg::ST_RACK: begin
				if (fall) begin
					if (rw_q) begin
						// read data fetched during the acknowledge pulse
						st_q     <= hsp_pkg::ST_TX;
						tx_q     <= rdat_q;
						sda_oe_q <= ~rdat_q[7];
					end else begin
						st_q     <= hsp_pkg::ST_RX;
						sda_oe_q <= 1'b0;
						if (ph_q == hsp_pkg::PH_ADDR) begin
							ph_q <= hsp_pkg::PH_SUB;
						end else begin
							ph_q <= hsp_pkg::PH_DATA;
						end
					end
				end
			end
			hsp_pkg::ST_TX: begin
				if (fall) begin
					if (cnt_q == hsp_pkg::BYTE_LAST) begin
						cnt_q    <= 4'h0;
						sda_oe_q <= 1'b0;
						st_q     <= hsp_pkg::ST_TACK;
					end else begin
						cnt_q    <= cnt_q + 4'h1;
						tx_q     <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[6];
					end
				end
			end
			hsp_pkg::ST_TACK: begin
				if (rise) begin
					mack_q  <= ~sda_s;
					ptr_q   <= ptr_q + 8'h01;
					rd_ev_q <= ~sda_s;
				end else if (fall) begin
					if (mack_q) begin
						st_q     <= hsp_pkg::ST_TX;
						tx_q     <= rdat_q;
						sda_oe_q <= ~rdat_q[7];
					end else begin
						st_q <= hsp_pkg::ST_WAIT;
					end
				end
			end
			hsp_pkg::ST_IDLE, hsp_pkg::ST_WAIT: begin
				sda_oe_q <= 1'b0;
			end
			default: begin
				st_q <= hsp_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// never pulls the clock: no stretching, no start or stop of its own
	always_ff @(posedge link_clk) begin
		lo_q <= 1'b0;
	end

	assign bus.dev_scl_o  = lo_q;
	assign bus.dev_scl_oe = lo_q;
	assign bus.dev_sda_o  = lo_q;
	assign bus.dev_sda_oe = sda_oe_q;

	// ------------------------------------------------------------
	// crossings to the system clock
	// ------------------------------------------------------------
	logic wr_p;
	logic rd_p;

	hsp_pulse_sync u_wr_sync (
		.src_clk   (link_clk),
		.src_rst   (lrst),
		.src_pulse (wr_ev_q),
		.dst_clk   (sys_clk),
		.dst_rst   (rst),
		.dst_pulse (wr_p)
	);

	hsp_pulse_sync u_rd_sync (
		.src_clk   (link_clk),
		.src_rst   (lrst),
		.src_pulse (rd_ev_q),
		.dst_clk   (sys_clk),
		.dst_rst   (rst),
		.dst_pulse (rd_p)
	);

	// ------------------------------------------------------------
	// user strobes
	// ------------------------------------------------------------
	logic       reg_wr_q;
	logic [7:0] reg_waddr_q;
	logic [7:0] reg_wdata_q;
	logic       reg_rd_q;
	logic [7:0] reg_raddr_q;

	// wa, wd and ptr stay still for a whole byte time after the event,
	// so the words are safe to sample once the pulse arrives
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_wr_q    <= 1'b0;
			reg_waddr_q <= 8'h00;
			reg_wdata_q <= 8'h00;
			reg_rd_q    <= 1'b0;
			reg_raddr_q <= 8'h00;
			rdat_q      <= 8'h00;
		end else begin
			reg_wr_q <= wr_p;
			reg_rd_q <= rd_p;
			if (wr_p) begin
				reg_waddr_q <= wa_q;
				reg_wdata_q <= wd_q;
			end
			if (rd_p) begin
				reg_raddr_q <= ptr_q;
			end
			if (reg_rd_q) begin
				// limitation: fetch must finish within the acknowledge pulse
				rdat_q <= reg_rdata;
			end
		end
	end

	assign reg_wr    = reg_wr_q;
	assign reg_waddr = reg_waddr_q;
	assign reg_wdata = reg_wdata_q;
	assign reg_rd    = reg_rd_q;
	assign reg_raddr = reg_raddr_q;

endmodule : hsp_dev

//--- hsp_pkg.sv
// Purpose: shared constants and types of the host serial port
// Assumes: 40 MHz system clock, two-wire bus at up to 400 kbit/s
// Notes:   address bytes are the full 8-bit form, direction bit zero
package hsp_pkg;

	// ------------------------------------------------------------
	// addressing and framing
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SEL0 = 8'hB8;
	localparam logic [7:0] ADDR_SEL1 = 8'hBA;
	localparam int         RW_BIT    = 0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BYTE_LAST = BYTE_BITS - 4'h1;
	localparam logic [7:0] PTR_RST   = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SYS_HZ     = 40000000;
	localparam int SCL_MAX_HZ = 400000;
	// quarter bit period, rounded up so the bus never runs too fast
	localparam int QTR_CYC = (SYS_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} hsp_cmd_e;
	typedef enum {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_WAIT} hsp_dev_st_e;
	typedef enum {PH_ADDR, PH_SUB, PH_DATA} hsp_phase_e;
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} hsp_host_st_e;

endpackage : hsp_pkg

//--- hsp_if.sv
// Purpose: open-drain two-wire bus joining master and slave ends
// Assumes: pull-ups on both lines
// Notes:   a line is low while any end enables a low drive
`timescale 1ns/100ps
interface hsp_if;

	// ------------------------------------------------------------
	// per-end drives and resolved lines
	// ------------------------------------------------------------
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (input scl, input sda,
		output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda,
		output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);

endinterface : hsp_if

//--- hsp_pulse_sync.sv
// Purpose: carries a one-cycle event from one clock domain to another
// Assumes: events spaced by several destination clock cycles
// Notes:   toggle crossing, output pulse is registered
`timescale 1ns/100ps
module hsp_pulse_sync (
	// source domain
	input  wire logic src_clk,
	input  wire logic src_rst,
	input  wire logic src_pulse,
	// destination domain
	input  wire logic dst_clk,
	input  wire logic dst_rst,
	output logic      dst_pulse
);

	logic tgl_q;
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic pulse_q;

	always_ff @(posedge src_clk) begin
		if (src_rst) begin
			tgl_q <= 1'b0;
		end else if (src_pulse) begin
			tgl_q <= ~tgl_q;
		end
	end

	// s1 feeds only s2
	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			s1_q    <= tgl_q;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			pulse_q <= s2_q ^ s3_q;
		end
	end

	assign dst_pulse = pulse_q;

endmodule : hsp_pulse_sync

//--- hsp_host.sv
// Purpose: byte-level two-wire bus master driven by a command port
// Assumes: slave never stretches the clock
// Notes:   clock made from sys_clk, four quarter periods per bit
`timescale 1ns/100ps
module hsp_host #(
	parameter int QTR_CYC = hsp_pkg::QTR_CYC
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// commands
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire hsp_pkg::hsp_cmd_e cmd_kind,
	input  wire logic [7:0]        cmd_data,
	input  wire logic              cmd_last,
	// byte results
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_nack,
	// bus
	hsp_if.host                    bus
);

	localparam logic [7:0] DIV_LAST = 8'(QTR_CYC - 1);

	// ------------------------------------------------------------
	// data line synchroniser and quarter-period divider
	// ------------------------------------------------------------
	logic sda_m;
	logic sda_s;

	always_ff @(posedge sys_clk) begin
		sda_m <= bus.sda;
		sda_s <= sda_m;
	end

	hsp_pkg::hsp_host_st_e st_q;
	logic [7:0]            div_q;
	logic                  tick;

	assign tick = (div_q == DIV_LAST);

	always_ff @(posedge sys_clk) begin
		if (rst || st_q == hsp_pkg::H_IDLE || tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	logic [1:0] qph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic       rd_q;
	logic       last_q;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       lo_q;
	logic       ready_q;
	logic       rsp_valid_q;
	logic [7:0] rsp_data_q;
	logic       rsp_nack_q;

	always_ff @(posedge sys_clk) begin
		rsp_valid_q <= 1'b0;
		if (rst) begin
			st_q       <= hsp_pkg::H_IDLE;
			qph_q      <= 2'h0;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			rd_q       <= 1'b0;
			last_q     <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
			ready_q    <= 1'b1;
			rsp_data_q <= 8'h00;
			rsp_nack_q <= 1'b0;
		end else if (st_q == hsp_pkg::H_IDLE) begin
			if (cmd_valid && ready_q) begin
				ready_q <= 1'b0;
				qph_q   <= 2'h0;
				bit_q   <= 4'h0;
				sh_q    <= cmd_data;
				rd_q    <= (cmd_kind == hsp_pkg::CMD_READ);
				last_q  <= cmd_last;
				case (cmd_kind)
				hsp_pkg::CMD_START: st_q <= hsp_pkg::H_START;
				hsp_pkg::CMD_STOP:  st_q <= hsp_pkg::H_STOP;
				default:            st_q <= hsp_pkg::H_BIT;
				endcase
			end
		end else if (tick) begin
			qph_q <= qph_q + 2'h1;
			case (st_q)
			hsp_pkg::H_START: begin
				case (qph_q)
				2'h0:    sda_oe_q <= 1'b0;
				2'h1:    scl_oe_q <= 1'b0;
				2'h2:    sda_oe_q <= 1'b1;
				default: begin
					scl_oe_q <= 1'b1;
					st_q     <= hsp_pkg::H_IDLE;
					ready_q  <= 1'b1;
				end
				endcase
			end
			hsp_pkg::H_STOP: begin
				case (qph_q)
				2'h0:    sda_oe_q <= 1'b1;
				2'h1:    scl_oe_q <= 1'b0;
				2'h2:    sda_oe_q <= 1'b0;
				default: begin
					st_q    <= hsp_pkg::H_IDLE;
					ready_q <= 1'b1;
				end
				endcase
			end
			hsp_pkg::H_BIT: begin
				case (qph_q)
				2'h0: begin
					// data only moves while the clock is low
					if (bit_q != hsp_pkg::BYTE_BITS) begin
						sda_oe_q <= ~rd_q & ~sh_q[7];
					end else begin
						sda_oe_q <= rd_q & ~last_q;
					end
				end
				2'h1: scl_oe_q <= 1'b0;
				2'h2: begin
					if (bit_q != hsp_pkg::BYTE_BITS) begin
						sh_q <= {sh_q[6:0], sda_s};
					end else begin
						rsp_nack_q <= sda_s;
					end
				end
				default: begin
					scl_oe_q <= 1'b1;
					if (bit_q == hsp_pkg::BYTE_BITS) begin
						st_q        <= hsp_pkg::H_IDLE;
						ready_q     <= 1'b1;
						rsp_valid_q <= 1'b1;
						rsp_data_q  <= sh_q;
					end else begin
						bit_q <= bit_q + 4'h1;
					end
				end
				endcase
			end
			default: begin
				st_q    <= hsp_pkg::H_IDLE;
				ready_q <= 1'b1;
			end
			endcase
		end
	end

	// pins only ever pull low
	always_ff @(posedge sys_clk) begin
		lo_q <= 1'b0;
	end

	assign bus.host_scl_o  = lo_q;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_o  = lo_q;
	assign bus.host_sda_oe = sda_oe_q;
	assign cmd_ready       = ready_q;
	assign rsp_valid       = rsp_valid_q;
	assign rsp_data        = rsp_data_q;
	assign rsp_nack        = rsp_nack_q;

endmodule : hsp_host

//--- hsp_monitor.sv
// Purpose: watches the two-wire lines between master and slave ends
// Assumes: link_clk samples far faster than the bus clock
// Notes:   helper logic tracks bit position, address byte and direction
`timescale 1ns/100ps
module hsp_monitor (
	// link domain
	input  wire logic link_clk,
	input  wire logic rst,
	// address select pin, frozen by the slave at reset release
	input  wire logic slave_address_select,
	// resolved lines
	input  wire logic scl,
	input  wire logic sda,
	// slave end drives
	input  wire logic dev_scl_o,
	input  wire logic dev_scl_oe,
	input  wire logic dev_sda_o,
	input  wire logic dev_sda_oe
);
	// ------------------------------------------------------------
	// bus tracking
	// ------------------------------------------------------------
	logic       scl_q, sda_q, first_q, rd_q, foreign_q, nack_q;
	logic [3:0] bits_q;
	logic [7:0] sh_q;
	logic       start_c, stop_c, rise_c, ninth_c;

	assign start_c = scl_q & scl & sda_q & ~sda;
	assign stop_c  = scl_q & scl & ~sda_q & sda;
	assign rise_c  = scl & ~scl_q;
	assign ninth_c = rise_c & (bits_q == 4'h8);

	// own address must include the select bit, not just the shared bits
	logic       sel_q;
	logic [7:0] own_c;

	assign own_c = sel_q ? hsp_pkg::ADDR_SEL1 : hsp_pkg::ADDR_SEL0;

	always_ff @(posedge link_clk) begin
		if (rst)
			sel_q <= slave_address_select;
	end

	always_ff @(posedge link_clk) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	always_ff @(posedge link_clk) begin
		if (rst | start_c)
			bits_q <= 4'h0;
		else if (rise_c)
			bits_q <= ninth_c ? 4'h0 : bits_q + 4'h1;
	end
	always_ff @(posedge link_clk) begin
		if (rise_c)
			sh_q <= {sh_q[6:0], sda};
	end
	always_ff @(posedge link_clk) begin
		if (rst | stop_c)
			first_q <= 1'b0;
		else if (start_c | ninth_c)
			first_q <= start_c;
	end
	always_ff @(posedge link_clk) begin
		if (rst | start_c)
			rd_q <= 1'b0;
		else if (ninth_c & first_q)
			rd_q <= sh_q[0];
	end
	// both flags only clear at reset or at a new start or stop
	always_ff @(posedge link_clk) begin
		if (rst | start_c | stop_c) begin
			foreign_q <= 1'b0;
			nack_q    <= 1'b0;
		end else if (ninth_c) begin
			foreign_q <= foreign_q | (first_q & (sh_q[7:1] != own_c[7:1]));
			nack_q    <= nack_q | (rd_q & ~first_q & sda);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst);

	AST_NO_SCL_DRIVE: assert property (!dev_scl_oe)
		else $error("slave drove the clock line");
	AST_LOW_ONLY: assert property (dev_sda_oe |-> !dev_sda_o && !dev_scl_o)
		else $error("slave drove a line high");
	AST_SDA_STEADY: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("slave changed data while clock high");
	AST_ADDR_MATCH: assert property (ninth_c && first_q && dev_sda_oe |->
		sh_q[7:1] == own_c[7:1])
		else $error("slave acknowledged a foreign address");
	AST_FOREIGN_QUIET: assert property (foreign_q |-> !dev_sda_oe)
		else $error("slave drove data after a foreign address");
	AST_WRITE_ACK: assert property (ninth_c && !first_q && !rd_q && !foreign_q |-> dev_sda_oe)
		else $error("slave missed a write acknowledge");
	AST_NACK_RELEASE: assert property (nack_q |-> !dev_sda_oe)
		else $error("slave drove data after a not-acknowledge");
	AST_DRIVE_HELD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe until_with $fell(scl))
		else $error("slave released data before clock fell");
	AST_DRIVE_BOUND: assert property ($rose(dev_sda_oe) |-> ##[1:120] $fell(scl))
		else $error("no clock fall after slave drive");

endmodule : hsp_monitor

//--- tb_top.sv
// Purpose: master and slave ends back to back over the two-wire bus
// Assumes: link clock 32 ns, host quarter period shortened to 6 cycles
// Notes:   driver queues expected bytes, a watcher checks them
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam int QTR   = 6;
	localparam int LIMIT = 20000;
	logic              sys_clk, link_clk, rst, slave_address_select, reg_wr, reg_rd;
	logic              cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_nack;
	hsp_pkg::hsp_cmd_e cmd_kind;
	logic [7:0]        cmd_data, rsp_data, reg_waddr, reg_wdata, reg_raddr, reg_rdata, ptr;
	logic [7:0]        regs [256];
	logic [8:0]        exp_rsp [$];
	logic [15:0]       exp_wr [$];
	logic [7:0]        exp_rd [$];
	logic [31:0]       rnd;
	int                bad_count = 0, n_compared = 0, cyc = 0;

	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	initial begin
		link_clk = 1'b0;
		#3;
		forever #16 link_clk = ~link_clk;
	end

	hsp_if i_hsp_if ();
	hsp_dev i_hsp_dev (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
		.link_clk(link_clk), .slave_address_select(slave_address_select), .bus(i_hsp_if.dev));
	hsp_host #(.QTR_CYC(QTR)) i_hsp_host (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_last(cmd_last),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus(i_hsp_if.host));
	hsp_monitor i_hsp_monitor (.link_clk(link_clk), .rst(rst),
		.slave_address_select(slave_address_select), .scl(i_hsp_if.scl),
		.sda(i_hsp_if.sda), .dev_scl_o(i_hsp_if.dev_scl_o), .dev_scl_oe(i_hsp_if.dev_scl_oe),
		.dev_sda_o(i_hsp_if.dev_sda_o), .dev_sda_oe(i_hsp_if.dev_sda_oe));

	// register space answers combinationally within the fetch cycle
	assign reg_rdata = regs[reg_raddr];

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// extra edge at the end so a late ready drop cannot re-take the command
	task automatic send(input hsp_pkg::hsp_cmd_e k, input logic [7:0] d, input logic l,
		input logic [8:0] e);
		if (k == hsp_pkg::CMD_WRITE || k == hsp_pkg::CMD_READ)
			exp_rsp.push_back(e);
		@(negedge sys_clk);
		while (cmd_ready !== 1'b1)
			@(negedge sys_clk);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_kind  <= k;
		cmd_data  <= d;
		cmd_last  <= l;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
	endtask : send

	task automatic do_reset(input logic s);
		@(posedge sys_clk);
		rst <= 1'b1;
		slave_address_select <= s;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		slave_address_select <= ~s;
		ptr = hsp_pkg::PTR_RST;
	endtask : do_reset

	task automatic wr_txn(input logic [7:0] a, input logic [7:0] sub, input int n,
		input logic ok);
		logic [7:0] d;
		send(hsp_pkg::CMD_START, 8'h00, 1'b0, 9'h000);
		send(hsp_pkg::CMD_WRITE, a, 1'b0, {~ok, a});
		send(hsp_pkg::CMD_WRITE, sub, 1'b0, {~ok, sub});
		if (ok)
			ptr = sub;
		for (int i = 0; i < n; i++) begin
			rnd = lfsr_next(rnd);
			d = rnd[7:0];
			if (ok) begin
				exp_wr.push_back({ptr, d});
				regs[ptr] = d;
				ptr++;
			end
			send(hsp_pkg::CMD_WRITE, d, 1'b0, {~ok, d});
		end
		send(hsp_pkg::CMD_STOP, 8'h00, 1'b0, 9'h000);
	endtask : wr_txn

	task automatic rd_txn(input logic [7:0] a, input int n, input logic ok);
		send(hsp_pkg::CMD_START, 8'h00, 1'b0, 9'h000);
		send(hsp_pkg::CMD_WRITE, a | 8'h01, 1'b0, {~ok, a | 8'h01});
		for (int i = 0; i < n; i++) begin
			// each byte is fetched once, at the address or at the prior master ack
			if (ok)
				exp_rd.push_back(ptr);
			send(hsp_pkg::CMD_READ, 8'h00, i == n - 1, {i == n - 1, regs[ptr]});
			ptr++;
		end
		send(hsp_pkg::CMD_STOP, 8'h00, 1'b0, 9'h000);
	endtask : rd_txn

	// ------------------------------------------------------------
	// watcher and timeout
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		logic [8:0]  er;
		logic [15:0] ew;
		logic [7:0]  ea;
		if (rst === 1'b0 && reg_rd === 1'b1) begin
			ea = exp_rd.size() > 0 ? exp_rd.pop_front() : {8{1'bx}};
			`CHK("register fetch", ea, reg_raddr)
		end
		if (rst === 1'b0 && rsp_valid === 1'b1) begin
			er = exp_rsp.size() > 0 ? exp_rsp.pop_front() : {9{1'bx}};
			`CHK("byte result", er, {rsp_nack, rsp_data})
		end
		if (rst === 1'b0 && reg_wr === 1'b1) begin
			ew = exp_wr.size() > 0 ? exp_wr.pop_front() : {16{1'bx}};
			`CHK("register write", ew, {reg_waddr, reg_wdata})
		end
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		slave_address_select = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = hsp_pkg::CMD_START;
		cmd_data = 8'h00;
		cmd_last = 1'b0;
		rnd = 32'h0001_2223;
		for (int i = 0; i < 256; i++) begin
			rnd = lfsr_next(rnd);
			regs[i] = rnd[7:0];
		end
		do_reset(1'b0);
		wr_txn(hsp_pkg::ADDR_SEL0, 8'h10, 3, 1'b1);
		wr_txn(hsp_pkg::ADDR_SEL0, 8'h10, 0, 1'b1);
		rd_txn(hsp_pkg::ADDR_SEL0, 3, 1'b1);
		rd_txn(hsp_pkg::ADDR_SEL0, 1, 1'b1);
		wr_txn(hsp_pkg::ADDR_SEL1, 8'h20, 1, 1'b0);
		rd_txn(hsp_pkg::ADDR_SEL1, 0, 1'b0);
		do_reset(1'b1);
		wr_txn(hsp_pkg::ADDR_SEL0, 8'h30, 1, 1'b0);
		wr_txn(hsp_pkg::ADDR_SEL1, 8'hF0, 2, 1'b1);
		wr_txn(hsp_pkg::ADDR_SEL1, 8'hF0, 0, 1'b1);
		rd_txn(hsp_pkg::ADDR_SEL1, 2, 1'b1);
		repeat (50) @(posedge sys_clk);
		`CHK("results left", 0, exp_rsp.size() + exp_wr.size() + exp_rd.size())
		complete_run();
	end

endmodule : tb_top
